/* File: hw/bcs_map.svh */
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH
// ----------------------------------------
// clock and time base
// ----------------------------------------
`define CLK_HZ 25000000
`define TICK_MS 1
`define MS_PER_S 1000
`define MS_PER_MIN 60000
// ----------------------------------------
// converter and history
// ----------------------------------------
`define ADC_W 10
`define ADC_LSB_MV 5
`define HIST_DEPTH 64
`define HIST_AW 6
`define TEMP_SENSE_INPUT_LAG_S 60
`define TEMP_SENSE_INPUT_DROP_HI_MV 40
`define TEMP_SENSE_INPUT_DROP_C2_MV 28
`define VSLOPE_MIN_N 4
`define VSLOPE_HYST 2
`define VSLOPE_ZERO 1
// ----------------------------------------
// pulse pattern, ms
// ----------------------------------------
`define FAST_PER_MS 1000
`define CHG_MS 800
`define DISCHARGE_ENABLE_OUT_MS 4
`define REST_MS 10
`define ACQ_MS 20
`define DSER_N 8
`define DSER_PER_MS 20
`define POLL_PULSE_MS 100
`define POLL_PER_MS 1000
`define POLL_MS 10000
`define TOP_MS 7200000
`define MAINT_MULT 4
`define FLASH_HALF_MS 500
`define MRST_MS 700
// ----------------------------------------
// per-rate tables
// ----------------------------------------
`define TOP_S_4C 40
`define TOP_S_2C 20
`define TOP_S_1C 10
`define TOP_S_C2 5
`define FT_4C_MIN 30
`define FT_2C_MIN 60
`define FT_1C_MIN 90
`define FT_C2_MIN 210
// ----------------------------------------
// registers
// ----------------------------------------
`define REG_CTRL 2'h0
`define REG_STAT 2'h1
`define REG_CAUSE 2'h2
`define CTRL_RST 8'h00
`define CTRL_INHIBIT 0
`define CAUSE_PEAK 0
`define CAUSE_ZERO 1
`define CAUSE_TEMP_SENSE_INPUT 2
`define CAUSE_TIMER 3
`endif

/* File: hw/bcs_pkg.sv */
package bcs_pkg;
  typedef enum logic [6:0] {
    ST_DISCH = 7'h01,
    ST_POLL = 7'h02,
    ST_FAST = 7'h04,
    ST_TOP = 7'h08,
    ST_MAINT = 7'h10,
    ST_HOT = 7'h20,
    ST_FAULT = 7'h40
  } bcs_stage_t;
  typedef enum logic [1:0] {
    RATE_4C = 2'h0,
    RATE_2C = 2'h1,
    RATE_1C = 2'h2,
    RATE_C2 = 2'h3
  } bcs_rate_t;
endpackage : bcs_pkg

/* File: hw/bcs_sync.sv */
`timescale 1ns/1ps
module bcs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= '0;
      o_q <= '0;
    end
    else
    begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule : bcs_sync

/* File: hw/bcs_hist_mem.sv */
`timescale 1ns/1ps
module bcs_hist_mem #(
  parameter int W = 10,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // write port
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [W-1:0] i_wr_data,
  // read port
  input wire logic i_rd_en,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [W-1:0] o_rd_data
);
  logic [W-1:0] mem [DEPTH];
  always_ff @(posedge i_clk)
  begin
    if (i_wr_en)
      mem[i_wr_addr] <= i_wr_data;
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rd_data <= '0;
    else if (i_rd_en)
      o_rd_data <= mem[i_rd_addr];
  end
endmodule : bcs_hist_mem

/* File: hw/bcs_top.sv */
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "bcs_map.svh"
// Notes on behaviour
// RULE1: topping runs two hours after termination
// RULE2: topping reuses fast pulses, longer spacing
// RULE3: mode indicator flashes 1 s in topping/maintenance
// RULE4: after topping, maintenance at 4x spacing
// RULE5: maintenance lasts while battery stays present
// RULE6: termination select adds thermistor methods
// RULE7: stop when voltage slope passes maximum
// RULE8: stop when slope flattens near zero
// RULE9: stop on thermistor drop over rate limit
// RULE10: thermistor slope also enables hot cutoff; the code runs hot cutoff with either termination select
// RULE11: thermistor below hot threshold shuts down
// RULE12: open thermal switch shuts down
// RULE13: hot shutdown holds until master reset
// RULE14: grounded thermistor input bypasses hot cutoff
// RULE15: fast charge timer always ends charge
// RULE16: discharge pulse series after reset
// RULE17: no battery after series starts polling
// RULE18: 100 ms poll pulse, 2.0 V compare
// RULE19: poll 10 s then detect or shut down
// RULE20: removal after fast start shuts down
// RULE21: gap check under 0.5 V in low stages
// RULE22: master reset low over 700 ms holds reset
// RULE23: rate straps pick spacing and timer
// RULE24: active-high charge and discharge requests
// RULE25: fast pulse cycle repeats every second
// RULE26: all timing counted from the clock
// RULE27: comparator inputs synchronised before use
module bcs_top #(
  parameter int P_TICK_CYC = `CLK_HZ / 1000 * `TICK_MS,
  parameter int P_ADC_W = `ADC_W
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // battery and thermistor sensing
  input wire logic I_VIN_ABOVE_PRES,
  input wire logic I_VIN_ABOVE_POLL,
  input wire logic [P_ADC_W-1:0] I_VIN_SAMPLE,
  input wire logic I_TEMP_SENSE_INPUT_BELOW_HOT,
  input wire logic I_TEMP_SENSE_INPUT_SWITCH_OPEN,
  input wire logic I_TEMP_SENSE_INPUT_GROUNDED,
  input wire logic [P_ADC_W-1:0] I_TEMP_SENSE_INPUT_SAMPLE,
  // straps and master reset
  input wire logic I_RATE_SELECT_LO,
  input wire logic I_RATE_SELECT_HI,
  input wire logic I_TERMINATION_SELECT,
  input wire logic I_MASTER_RESET_N,
  // register port
  input wire logic [1:0] I_ADDR,
  input wire logic [7:0] I_WR_DATA,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  output logic [7:0] O_RD_DATA,
  // charger control and indicators
  output logic O_CHARGE_ENABLE_OUT,
  output logic O_DISCHARGE_ENABLE_OUT,
  output logic O_POLLING_FAULT_INDICATOR_N,
  output logic O_CHARGE_MODE_INDICATOR_N,
  output logic O_TEMP_RANGE_INDICATOR_N
);
  localparam int L_SW = 9 + 2 * P_ADC_W;
  localparam logic signed [P_ADC_W:0] L_HYST = (P_ADC_W + 1)'(`VSLOPE_HYST);
  localparam logic signed [P_ADC_W:0] L_ZERO = (P_ADC_W + 1)'(`VSLOPE_ZERO);
  localparam logic [17:0] L_ACQ_END = 18'(`CHG_MS + `DISCHARGE_ENABLE_OUT_MS + `REST_MS + `ACQ_MS - 1);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [7:0] top_s(input bcs_pkg::bcs_rate_t r);
    unique case (r)
      bcs_pkg::RATE_4C: top_s = 8'(`TOP_S_4C);
      bcs_pkg::RATE_2C: top_s = 8'(`TOP_S_2C);
      bcs_pkg::RATE_1C: top_s = 8'(`TOP_S_1C);
      bcs_pkg::RATE_C2: top_s = 8'(`TOP_S_C2);
    endcase
  endfunction : top_s

  function automatic logic [23:0] fast_lim(input bcs_pkg::bcs_rate_t r);
    unique case (r)
      bcs_pkg::RATE_4C: fast_lim = 24'(`FT_4C_MIN * `MS_PER_MIN);
      bcs_pkg::RATE_2C: fast_lim = 24'(`FT_2C_MIN * `MS_PER_MIN);
      bcs_pkg::RATE_1C: fast_lim = 24'(`FT_1C_MIN * `MS_PER_MIN);
      bcs_pkg::RATE_C2: fast_lim = 24'(`FT_C2_MIN * `MS_PER_MIN);
    endcase
  endfunction : fast_lim

  function automatic logic [17:0] period(input bcs_pkg::bcs_stage_t s, input bcs_pkg::bcs_rate_t r);
    unique case (s)
      bcs_pkg::ST_FAST: period = 18'(`FAST_PER_MS);
      bcs_pkg::ST_TOP: period = 18'(top_s(r) * `MS_PER_S);
      bcs_pkg::ST_MAINT: period = 18'(top_s(r) * `MS_PER_S * `MAINT_MULT);
      bcs_pkg::ST_POLL: period = 18'(`POLL_PER_MS);
      default: period = 18'(`DSER_PER_MS);
    endcase
  endfunction : period

  // ----------------------------------------
  // input synchronisers and ms tick
  // ----------------------------------------
  logic [L_SW-1:0] sync_w;
  logic pres_s, poll_s, hot_s, open_s, gnd_s, rs_lo_s, rs_hi_s, tsel_s, mr_n_s;
  logic [P_ADC_W-1:0] vin_s, temp_sense_input_s;
  bcs_sync #(.W(L_SW)) u_sync (
    .i_clk(I_CLK),
    .i_rst_n(I_RSTN),
    .i_d({I_TEMP_SENSE_INPUT_SAMPLE, I_VIN_SAMPLE, I_MASTER_RESET_N, I_TERMINATION_SELECT, I_RATE_SELECT_HI,
          I_RATE_SELECT_LO, I_TEMP_SENSE_INPUT_GROUNDED, I_TEMP_SENSE_INPUT_SWITCH_OPEN, I_TEMP_SENSE_INPUT_BELOW_HOT, I_VIN_ABOVE_POLL,
          I_VIN_ABOVE_PRES}),
    .o_q(sync_w)
  ); // RULE27
  assign {temp_sense_input_s, vin_s, mr_n_s, tsel_s, rs_hi_s, rs_lo_s, gnd_s, open_s, hot_s, poll_s, pres_s} = sync_w;

  logic [23:0] pre_q;
  logic tick_q;
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      pre_q <= '0;
      tick_q <= 1'b0;
    end
    else if (pre_q == 24'(P_TICK_CYC - 1))
    begin
      pre_q <= '0;
      tick_q <= 1'b1; // RULE26
    end
    else
    begin
      pre_q <= pre_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // master reset filter
  // ----------------------------------------
  logic [9:0] mr_ms_q;
  logic mr_hold;
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      mr_ms_q <= '0;
    else if (mr_n_s)
      mr_ms_q <= '0;
    else if (tick_q && mr_ms_q <= 10'(`MRST_MS))
      mr_ms_q <= mr_ms_q + 10'h001;
  end
  assign mr_hold = mr_ms_q > 10'(`MRST_MS); // RULE22

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  bcs_pkg::bcs_stage_t state_q, state_d;
  bcs_pkg::bcs_rate_t rate_q;
  logic tsel_q, inhibit;
  logic [17:0] cyc_ms_q;
  logic [23:0] stage_ms_q;
  logic [3:0] dser_n_q;
  logic pulse_st, chg_ph, discharge_enable_out_ph, acq_end, cyc_end, poll_end, gap_fault, fast_fault, hot_trip;
  logic vpeak, vzero, tterm, timer_end, fast_done;

  assign pulse_st = state_q inside {bcs_pkg::ST_FAST, bcs_pkg::ST_TOP, bcs_pkg::ST_MAINT};
  assign chg_ph = (pulse_st && cyc_ms_q < 18'(`CHG_MS)) ||
                  (state_q == bcs_pkg::ST_POLL && cyc_ms_q < 18'(`POLL_PULSE_MS)); // RULE2 RULE18
  assign discharge_enable_out_ph = (pulse_st && cyc_ms_q >= 18'(`CHG_MS) && cyc_ms_q < 18'(`CHG_MS + `DISCHARGE_ENABLE_OUT_MS)) ||
                   (state_q == bcs_pkg::ST_DISCH && cyc_ms_q < 18'(`DISCHARGE_ENABLE_OUT_MS)); // RULE16
  assign acq_end = tick_q && state_q == bcs_pkg::ST_FAST && cyc_ms_q == L_ACQ_END;
  assign cyc_end = tick_q && cyc_ms_q == period(state_q, rate_q) - 18'h00001; // RULE25 RULE23
  assign poll_end = tick_q && state_q == bcs_pkg::ST_POLL && cyc_ms_q == 18'(`POLL_PULSE_MS - 1);
  assign gap_fault = tick_q && state_q inside {bcs_pkg::ST_TOP, bcs_pkg::ST_MAINT} &&
                     !chg_ph && !discharge_enable_out_ph && !pres_s; // RULE21 RULE5
  assign fast_fault = (acq_end && !pres_s) || (tick_q && state_q == bcs_pkg::ST_FAST && chg_ph && poll_s); // RULE20
  // hot cutoff is on with or without the slope method, unless the input is grounded
  assign hot_trip = !gnd_s && (hot_s || open_s) &&
                    state_q inside {bcs_pkg::ST_DISCH, bcs_pkg::ST_POLL, bcs_pkg::ST_FAST,
                                    bcs_pkg::ST_TOP, bcs_pkg::ST_MAINT}; // RULE10 RULE11 RULE12 RULE14
  assign timer_end = tick_q && state_q == bcs_pkg::ST_FAST && stage_ms_q == fast_lim(rate_q) - 24'h000001; // RULE15
  assign fast_done = vpeak || vzero || tterm || timer_end;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      bcs_pkg::ST_DISCH:
        if (cyc_end && dser_n_q == 4'(`DSER_N - 1))
          state_d = pres_s ? bcs_pkg::ST_FAST : bcs_pkg::ST_POLL; // RULE17
      bcs_pkg::ST_POLL:
        if (poll_end && !poll_s)
          state_d = bcs_pkg::ST_FAST; // RULE19
        else if (tick_q && stage_ms_q == 24'(`POLL_MS - 1))
          state_d = bcs_pkg::ST_FAULT; // RULE19
      bcs_pkg::ST_FAST:
        if (fast_fault)
          state_d = bcs_pkg::ST_FAULT;
        else if (fast_done)
          state_d = bcs_pkg::ST_TOP;
      bcs_pkg::ST_TOP:
        if (gap_fault)
          state_d = bcs_pkg::ST_FAULT;
        else if (tick_q && stage_ms_q == 24'(`TOP_MS - 1))
          state_d = bcs_pkg::ST_MAINT; // RULE1 RULE4
      bcs_pkg::ST_MAINT:
        if (gap_fault)
          state_d = bcs_pkg::ST_FAULT;
      bcs_pkg::ST_HOT, bcs_pkg::ST_FAULT:
        state_d = state_q; // RULE13
      default:
        state_d = bcs_pkg::ST_DISCH;
    endcase
    if (hot_trip)
      state_d = bcs_pkg::ST_HOT;
    if (mr_hold)
      state_d = bcs_pkg::ST_DISCH;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      state_q <= bcs_pkg::ST_DISCH;
    else
      state_q <= state_d;
  end

  // straps only take effect through a reset
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      rate_q <= bcs_pkg::RATE_4C;
      tsel_q <= 1'b0;
    end
    else if (state_q == bcs_pkg::ST_DISCH)
    begin
      rate_q <= bcs_pkg::bcs_rate_t'({rs_lo_s, rs_hi_s}); // RULE23
      tsel_q <= tsel_s; // RULE6
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      cyc_ms_q <= '0;
      stage_ms_q <= '0;
      dser_n_q <= '0;
    end
    else if (state_d != state_q || mr_hold)
    begin
      cyc_ms_q <= '0;
      stage_ms_q <= '0;
      dser_n_q <= '0;
    end
    else if (tick_q)
    begin
      cyc_ms_q <= cyc_end ? 18'h00000 : cyc_ms_q + 18'h00001;
      stage_ms_q <= stage_ms_q + 24'h000001;
      if (cyc_end && state_q == bcs_pkg::ST_DISCH)
        dser_n_q <= dser_n_q + 4'h1;
    end
  end

  // ----------------------------------------
  // voltage slope
  // ----------------------------------------
  logic [P_ADC_W-1:0] v_prev_q;
  logic signed [P_ADC_W:0] vmax_q, slope;
  logic [2:0] vn_q;
  assign slope = $signed({1'b0, vin_s}) - $signed({1'b0, v_prev_q}); // RULE7
  assign vpeak = acq_end && vn_q == 3'(`VSLOPE_MIN_N) && vmax_q > L_HYST && slope < vmax_q - L_HYST; // RULE7
  assign vzero = acq_end && vn_q == 3'(`VSLOPE_MIN_N) && vmax_q > 0 && slope <= 0 && slope >= -L_ZERO; // RULE8

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      v_prev_q <= '0;
      vmax_q <= '0;
      vn_q <= '0;
    end
    else if (state_q != bcs_pkg::ST_FAST)
    begin
      vmax_q <= '0;
      vn_q <= '0;
    end
    else if (acq_end)
    begin
      v_prev_q <= vin_s;
      if (vn_q != 3'(`VSLOPE_MIN_N))
        vn_q <= vn_q + 3'h1;
      else if (slope > vmax_q)
        vmax_q <= slope;
    end
  end

  // ----------------------------------------
  // thermistor slope over one minute
  // ----------------------------------------
  logic [`HIST_AW-1:0] wr_ptr_q;
  logic [6:0] fill_q;
  logic eval_q;
  logic [P_ADC_W-1:0] temp_sense_input_new_q, hist_rd;
  logic [P_ADC_W+7:0] drop_mv, lim_mv;
  bcs_hist_mem #(.W(P_ADC_W), .DEPTH(`HIST_DEPTH), .AW(`HIST_AW)) u_hist (
    .i_clk(I_CLK),
    .i_rst_n(I_RSTN),
    .i_wr_en(acq_end),
    .i_wr_addr(wr_ptr_q),
    .i_wr_data(temp_sense_input_s),
    .i_rd_en(acq_end),
    .i_rd_addr(wr_ptr_q - `HIST_AW'(`TEMP_SENSE_INPUT_LAG_S)),
    .o_rd_data(hist_rd)
  );
  assign drop_mv = (P_ADC_W + 8)'((hist_rd - temp_sense_input_new_q) * `ADC_LSB_MV);
  assign lim_mv = (rate_q == bcs_pkg::RATE_C2) ? (P_ADC_W + 8)'(`TEMP_SENSE_INPUT_DROP_C2_MV) :
                  (P_ADC_W + 8)'(`TEMP_SENSE_INPUT_DROP_HI_MV);
  assign tterm = eval_q && tsel_q && state_q == bcs_pkg::ST_FAST && hist_rd > temp_sense_input_new_q &&
                 drop_mv > lim_mv; // RULE9

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      wr_ptr_q <= '0;
      fill_q <= '0;
      eval_q <= 1'b0;
      temp_sense_input_new_q <= '0;
    end
    else if (state_q != bcs_pkg::ST_FAST)
    begin
      fill_q <= '0;
      eval_q <= 1'b0;
    end
    else
    begin
      eval_q <= acq_end && fill_q == 7'(`TEMP_SENSE_INPUT_LAG_S);
      if (acq_end)
      begin
        wr_ptr_q <= wr_ptr_q + `HIST_AW'(1);
        temp_sense_input_new_q <= temp_sense_input_s;
        if (fill_q != 7'(`TEMP_SENSE_INPUT_LAG_S))
          fill_q <= fill_q + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // indicators and outputs
  // ----------------------------------------
  logic pf_seen_q, flash_q;
  logic [9:0] flash_ms_q;
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      pf_seen_q <= 1'b0;
    else if (state_q != bcs_pkg::ST_POLL)
      pf_seen_q <= 1'b0;
    else if (poll_end && poll_s)
      pf_seen_q <= 1'b1; // RULE18
  end

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      flash_ms_q <= '0;
      flash_q <= 1'b0;
    end
    else if (!(state_q inside {bcs_pkg::ST_TOP, bcs_pkg::ST_MAINT}))
    begin
      flash_ms_q <= '0;
      flash_q <= 1'b0;
    end
    else if (tick_q)
    begin
      if (flash_ms_q == 10'(`FLASH_HALF_MS - 1))
      begin
        flash_ms_q <= '0;
        flash_q <= !flash_q; // RULE3
      end
      else
        flash_ms_q <= flash_ms_q + 10'h001;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_CHARGE_ENABLE_OUT <= 1'b0;
      O_DISCHARGE_ENABLE_OUT <= 1'b0;
      O_POLLING_FAULT_INDICATOR_N <= 1'b1;
      O_CHARGE_MODE_INDICATOR_N <= 1'b1;
      O_TEMP_RANGE_INDICATOR_N <= 1'b1;
    end
    else
    begin
      O_CHARGE_ENABLE_OUT <= chg_ph && !inhibit && !mr_hold; // RULE24
      O_DISCHARGE_ENABLE_OUT <= discharge_enable_out_ph && !inhibit && !mr_hold; // RULE24
      O_POLLING_FAULT_INDICATOR_N <= !(state_q == bcs_pkg::ST_FAULT || pf_seen_q); // RULE19 RULE20
      O_CHARGE_MODE_INDICATOR_N <= state_q == bcs_pkg::ST_FAST ? 1'b0 : !flash_q; // RULE3
      O_TEMP_RANGE_INDICATOR_N <= state_q != bcs_pkg::ST_HOT; // RULE11 RULE12
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  logic [7:0] ctrl_q, cause_q;
  assign inhibit = ctrl_q[`CTRL_INHIBIT];
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      ctrl_q <= `CTRL_RST;
    else if (I_WR_EN && I_ADDR == `REG_CTRL)
      ctrl_q <= I_WR_DATA;
  end

  // cause is cleared only by a reset, so nothing can race it
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      cause_q <= 8'h00;
    else if (mr_hold)
      cause_q <= 8'h00;
    else if (state_q == bcs_pkg::ST_FAST && state_d == bcs_pkg::ST_TOP)
      cause_q <= {4'h0, timer_end, tterm, vzero, vpeak};
  end

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      O_RD_DATA <= 8'h00;
    else if (I_RD_EN)
      unique case (I_ADDR)
        `REG_CTRL: O_RD_DATA <= ctrl_q;
        `REG_STAT: O_RD_DATA <= {1'b0, state_q};
        `REG_CAUSE: O_RD_DATA <= cause_q;
        default: O_RD_DATA <= 8'h00;
      endcase
    else
      O_RD_DATA <= 8'h00;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  AST_NO_OVERLAP: assert property (!(O_CHARGE_ENABLE_OUT && O_DISCHARGE_ENABLE_OUT)) // RULE24
    else $error("charge and discharge both on");
  AST_MR_HOLD: assert property (mr_hold |=> state_q == bcs_pkg::ST_DISCH ##1 !O_CHARGE_ENABLE_OUT) // RULE22
    else $error("master reset not held");
  AST_HOT_TRIP: assert property (hot_trip && !mr_hold |=> state_q == bcs_pkg::ST_HOT ##1 !O_TEMP_RANGE_INDICATOR_N) // RULE11
    else $error("hot condition missed");
  AST_HOT_STAY: assert property (state_q == bcs_pkg::ST_HOT && $past(state_q) == bcs_pkg::ST_HOT
                                 |-> !O_CHARGE_ENABLE_OUT && !O_TEMP_RANGE_INDICATOR_N) // RULE13
    else $error("hot shutdown left");
  AST_FAST_LIMIT: assert property (state_q == bcs_pkg::ST_FAST |-> stage_ms_q < fast_lim(rate_q)) // RULE15
    else $error("fast timer overran");
  AST_TOP_LEN: assert property ($rose(state_q == bcs_pkg::ST_MAINT) |->
                                $past(state_q) == bcs_pkg::ST_TOP && $past(stage_ms_q) == 24'(`TOP_MS - 1)) // RULE1
    else $error("topping length wrong");
  AST_GAP_FAULT: assert property (gap_fault && !mr_hold && !hot_trip |=> state_q == bcs_pkg::ST_FAULT) // RULE21
    else $error("removal in gap missed");
  AST_POLL_END: assert property (state_q == bcs_pkg::ST_POLL && tick_q && stage_ms_q == 24'(`POLL_MS - 1) &&
                                 !mr_hold && !hot_trip |=> state_q == bcs_pkg::ST_FAULT ##1
                                 !O_POLLING_FAULT_INDICATOR_N) // RULE19
    else $error("polling did not time out");
  AST_FLASH_TICK: assert property ($changed(O_CHARGE_MODE_INDICATOR_N) && state_q == bcs_pkg::ST_TOP &&
                                   $past(state_q, 2) == bcs_pkg::ST_TOP |-> $past(tick_q, 2)) // RULE3
    else $error("flash off the ms tick");

  CVR_FAST: cover property (state_q == bcs_pkg::ST_FAST);
  CVR_TOP: cover property (state_q == bcs_pkg::ST_TOP);
  CVR_FAULT: cover property (state_q == bcs_pkg::ST_FAULT);
  CVR_HOT: cover property (state_q == bcs_pkg::ST_HOT);
endmodule : bcs_top

/* File: bench/bcs_batt_model.sv */
`timescale 1ns/1ps
module bcs_batt_model (
  // charger request
  input wire logic i_chg,
  input wire logic i_present,
  // terminal sensing
  output logic o_above_pres,
  output logic o_above_poll,
  output logic [9:0] o_vin_sample
);
  logic [3:0] lvl_q;
  // ------
  // cell or open terminal
  // ------
  // a cell clamps the terminal low; an open terminal rises only while current flows
  assign o_above_pres = i_present;
  assign o_above_poll = !i_present && i_chg;
  // climbs 4 codes per charge pulse, flat after six, so the slope peaks then drops
  always_ff @(negedge i_chg or negedge i_present)
  begin
    if (!i_present)
      lvl_q <= 4'h0;
    else if (lvl_q != 4'h6)
      lvl_q <= lvl_q + 4'h1;
  end
  assign o_vin_sample = i_present ? 10'h1F0 + {4'h0, lvl_q, 2'h0} : 10'h000;
endmodule : bcs_batt_model

/* File: bench/bcs_top_tb.sv */
`timescale 1ns/1ps
module bcs_top_tb;
  localparam int TK = 2;
  logic clk, rstn, present, hot, sw_open, gnd, mrst_n, wr_en, rd_en, seen;
  logic charge_enable_out, discharge_enable_out, pf_n, cm_n, tr_n, pres, poll;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [9:0] cell_voltage_input;
  int cnt;
  int n_mismatch = 0;
  int n_checks = 0;

  bcs_top #(.P_TICK_CYC(TK)) u_bcs_top (.I_CLK(clk), .I_RSTN(rstn), .I_VIN_ABOVE_PRES(pres),
    .I_VIN_ABOVE_POLL(poll), .I_VIN_SAMPLE(cell_voltage_input), .I_TEMP_SENSE_INPUT_BELOW_HOT(hot), .I_TEMP_SENSE_INPUT_SWITCH_OPEN(sw_open),
    .I_TEMP_SENSE_INPUT_GROUNDED(gnd), .I_TEMP_SENSE_INPUT_SAMPLE(10'h200), .I_RATE_SELECT_LO(1'b0), .I_RATE_SELECT_HI(1'b0),
    .I_TERMINATION_SELECT(1'b0), .I_MASTER_RESET_N(mrst_n), .I_ADDR(addr), .I_WR_DATA(wdata),
    .I_WR_EN(wr_en), .I_RD_EN(rd_en), .O_RD_DATA(rdata), .O_CHARGE_ENABLE_OUT(charge_enable_out),
    .O_DISCHARGE_ENABLE_OUT(discharge_enable_out), .O_POLLING_FAULT_INDICATOR_N(pf_n),
    .O_CHARGE_MODE_INDICATOR_N(cm_n), .O_TEMP_RANGE_INDICATOR_N(tr_n));
  bcs_batt_model u_bcs_batt_model (.i_chg(charge_enable_out), .i_present(present), .o_above_pres(pres),
    .o_above_poll(poll), .o_vin_sample(cell_voltage_input));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ------
  // shared tasks
  // ------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rv = rdata;
  endtask : rd

  task automatic wait_stage(input logic [7:0] s, input int lim);
    int i;
    i = 0;
    rd(2'h1);
    while (rv !== s && i < lim)
    begin
      rd(2'h1);
      i++;
    end
    if (rv !== s)
    begin
      chk("stage_wait", 16'(rv), 16'(s));
      finish_test();
    end
  endtask : wait_stage

  // sel 0 watches charge, 1 discharge; cnt holds cycles spent waiting
  task automatic wait_lvl(input int sel, input logic v, input int lim);
    cnt = 0;
    while ((sel == 0 ? charge_enable_out : discharge_enable_out) !== v)
    begin
      @(posedge clk);
      #1 cnt++;
      if (cnt > lim)
      begin
        chk("level_wait", 16'(cnt), 16'(lim));
        finish_test();
      end
    end
  endtask : wait_lvl

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  task automatic mreset();
    mrst_n <= 1'b0;
    repeat (705 * TK) @(posedge clk);
    rd(2'h1);
    chk("held", 16'({rv[0], charge_enable_out}), 16'h2);
    mrst_n <= 1'b1;
  endtask : mreset

  // ------
  // scenarios
  // ------
  task automatic s_reset();
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1 chk("rst_out", 16'({charge_enable_out, discharge_enable_out, pf_n, cm_n, tr_n}), 16'h07);
    rd(2'h1);
    chk("stat", 16'(rv), 16'h01);
    wr(2'h3, 8'hFF);
    rd(2'h3);
    chk("unmapped", 16'(rv), 16'h00);
    rd(2'h2);
    chk("cause", 16'(rv), 16'h00);
    // first pulse is stretched by the reset-to-tick phase, so time the second
    wait_lvl(1, 1'b0, 40 * TK);
    wait_lvl(1, 1'b1, 40 * TK);
    wait_lvl(1, 1'b0, 40 * TK);
    chk("disch_len", 16'(cnt), 16'(4 * TK));
  endtask : s_reset

  task automatic s_poll_fault();
    wait_stage(8'h02, 200 * TK);
    chk("poll", 16'(rv), 16'h02);
    wait_lvl(0, 1'b1, 1000 * TK);
    wait_lvl(0, 1'b0, 200 * TK);
    wait_lvl(0, 1'b1, 1000 * TK);
    wait_lvl(0, 1'b0, 200 * TK);
    chk("poll_len", 16'(cnt), 16'(100 * TK));
    chk("pf_on", 16'(pf_n), 16'h0);
    wait_stage(8'h40, 6000 * TK);
    repeat (1200 * TK) @(posedge clk);
    #1 chk("shut", 16'({charge_enable_out, pf_n}), 16'h0);
  endtask : s_poll_fault

  task automatic s_fast();
    present <= 1'b1;
    mreset();
    wait_stage(8'h04, 400 * TK);
    chk("fast", 16'({rv, cm_n}), 16'h008);
    wait_lvl(0, 1'b0, 1000 * TK);
    chk("discharge_enable_out_on", 16'(discharge_enable_out), 16'h1);
    wait_lvl(1, 1'b0, 10 * TK);
    chk("discharge_enable_out_len", 16'(cnt), 16'(4 * TK));
    wait_lvl(0, 1'b1, 300 * TK);
    chk("gap", 16'(cnt + 4 * TK), 16'(200 * TK));
    wait_lvl(0, 1'b0, 900 * TK);
    chk("chg_len", 16'(cnt), 16'(800 * TK));
    wr(2'h0, 8'h01);
    wr(2'h1, 8'hFF);
    seen = 1'b0;
    repeat (1100 * TK)
    begin
      @(posedge clk);
      #1 seen = seen | charge_enable_out | discharge_enable_out;
    end
    chk("inhibit", 16'(seen), 16'h0);
    rd(2'h1);
    chk("stat_ro", 16'(rv), 16'h04);
    wr(2'h0, 8'h00);
    present <= 1'b0;
    wait_stage(8'h40, 1100 * TK);
    chk("removed", 16'({rv, pf_n}), 16'h080);
  endtask : s_fast

  task automatic s_hot();
    for (int k = 0; k < 3; k++)
    begin
      present <= 1'b1;
      do_reset();
      wait_stage(8'h04, 400 * TK);
      hot <= (k == 0);
      sw_open <= (k != 0);
      gnd <= (k == 2);
      // the bypass case has no event to wait on, so give it a few ticks
      repeat (20 * TK) @(posedge clk);
      rd(2'h1);
      if (k == 2)
        chk("bypass", 16'(rv), 16'h04);
      else
        chk("hot", 16'({rv, tr_n, charge_enable_out}), 16'h080);
      hot <= 1'b0;
      sw_open <= 1'b0;
      gnd <= 1'b0;
      repeat (20 * TK) @(posedge clk);
      rd(2'h1);
      if (k == 0)
        chk("hot_held", 16'(rv), 16'h20);
    end
    // bypass pass left it charging; trip again so the master reset clears a hot stop
    sw_open <= 1'b1;
    repeat (20 * TK) @(posedge clk);
    sw_open <= 1'b0;
    rd(2'h1);
    chk("hot_again", 16'(rv), 16'h20);
    mreset();
    wait_stage(8'h04, 400 * TK);
    chk("restart", 16'(rv), 16'h04);
  endtask : s_hot

  task automatic s_top();
    present <= 1'b0;
    wait_stage(8'h40, 1100 * TK);
    present <= 1'b1;
    mreset();
    wait_stage(8'h04, 400 * TK);
    wait_stage(8'h08, 4000 * TK);
    rd(2'h2);
    chk("term_cause", 16'(rv), 16'h03);
    seen = cm_n;
    repeat (250 * TK) @(posedge clk);
    #1 seen = seen & cm_n;
    repeat (500 * TK) @(posedge clk);
    #1 chk("flash", 16'({seen, cm_n, charge_enable_out}), 16'h5);
    present <= 1'b0;
    wait_stage(8'h40, 200 * TK);
    chk("gap_removed", 16'({rv, pf_n}), 16'h080);
  endtask : s_top

  initial
  begin
    rstn = 1'b0;
    present = 1'b0;
    hot = 1'b0;
    sw_open = 1'b0;
    gnd = 1'b0;
    mrst_n = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    s_reset();
    s_poll_fault();
    s_fast();
    s_hot();
    s_top();
    finish_test();
  end
endmodule : bcs_top_tb
